// ==== hw/huisp_port.sv ====
// Notes on behaviour
// - Bit time is (count+1) or (count+33)*2^(exp-1) reference periods.
// - Exponent 0..7; count range 1..32 at zero exponent, else 33..64.
// - Setting 0x7a gives 115.2 kbit/s, 0x15 gives 1228.8 kbit/s.
// - Character is start 0, eight data bits, stop 1, no parity.
// - UART bytes travel least significant bit first.
// - UART read: one address byte in, one data byte out.
// - UART write: address then data; address byte is echoed.
// - I2C side is slave only; no clock, arbitration or high speed.
// - Clock line is never held low by this block.
// - General call and device-identification requests are ignored.
// - I2C runs up to 400 kbit/s or 1 Mbit/s.
// - Spike filtering on both I2C lines whenever I2C is selected.
// - Data line changes only while clock is low.
// - Start and stop are data edges while clock is high.
// - Bus busy from start to stop; repeated start acts as start.
// - I2C bytes go MSB first, each followed by an acknowledge.
// - Receiver pulls data low for acknowledge; transmitter releases.
// - On master not-acknowledge the slave releases the data line.
// - Address is fixed 5-bit prefix plus two pin or nonvolatile bits.
// - Bit rate defaults to 115.2 kbit/s after reset.
// - I2C write: pointer byte, then data to rising addresses except FIFO.
// - I2C read returns bytes from auto-increment pointer except FIFO.
`timescale 1ns/10ps
`default_nettype none
`include "huisp_consts.svh"

module huisp_port #(
	parameter logic [4:0] ADDR_PREFIX = 5'h13 // Arbitrary value
)(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Interface selection and address straps
	input wire logic i2c_mode,
	input wire logic adr1,
	input wire logic adr2,
	input wire logic use_nv_addr,
	input wire logic [1:0] nv_addr_lo,
	// UART pins
	input wire logic uart_rx,
	output logic uart_tx,
	input wire logic uart_read_trigger_pin,
	// I2C pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Register file read port
	output logic reg_re,
	output logic [6:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	// Register file write stream
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [6:0] wr_addr,
	output logic [7:0] wr_data,
	output logic wr_room
);
	import huisp_pkg::*;

	// ==========================================
	// Helpers
	// Bit time in reference periods
	function automatic logic [12:0] bit_ticks(input logic [7:0] b);
		logic [2:0] e;
		e = b[`HUISP_BAUD_EXP];
		if (e == 3'h0)
			return {8'h00, b[`HUISP_BAUD_CNT]} + `HUISP_DIV_ONE;
		return ({8'h00, b[`HUISP_BAUD_CNT]} + `HUISP_DIV_OFS) << (e - 3'h1);
	endfunction

	// Pointer step that holds at the FIFO address
	function automatic logic [6:0] next_ptr(input logic [6:0] p);
		return (p == `HUISP_FIFO_ADDR) ? p : p + 7'h01;
	endfunction

	localparam huisp_state_t ST_RST = huisp_rst_state();

	huisp_state_t st_r;
	huisp_state_t st_nxt;
	logic [16:0] acc_sum;
	logic u_tick;
	logic [12:0] nt;
	logic mode;
	logic rx;
	logic u_done;
	logic i_rise;
	logic i_fall;
	logic i_start;
	logic i_stop;
	logic [6:0] my_addr;
	logic addr_match;
	logic room;
	logic pop;
	logic [7:0] rd_val;
	logic push_v;
	logic [6:0] push_a;
	logic [7:0] push_d;
	logic load;
	logic slot;

	// ==========================================
	// Derived events
	assign acc_sum = st_r.acc + `HUISP_REF_KHZ;
	assign u_tick = acc_sum >= `HUISP_CLK_KHZ;
	assign nt = bit_ticks(st_r.baud);
	assign mode = st_r.flt[0];
	assign rx = st_r.flt[3];
	assign u_done = st_r.u_st == U_STOP && u_tick && st_r.u_cnt == 13'h0 && rx;
	assign i_rise = st_r.ln_f[0] && !st_r.ln_q[0];
	assign i_fall = !st_r.ln_f[0] && st_r.ln_q[0];
	assign i_start = st_r.ln_f[0] && st_r.ln_q[0] && st_r.ln_q[1] && !st_r.ln_f[1];
	assign i_stop = st_r.ln_f[0] && st_r.ln_q[0] && !st_r.ln_q[1] && st_r.ln_f[1];
	assign my_addr = {ADDR_PREFIX, use_nv_addr ? nv_addr_lo : {st_r.flt[5], st_r.flt[4]}};
	assign addr_match = st_r.i_sh[7:1] == my_addr && st_r.i_sh[7:1] != `HUISP_GCALL_ADDR
		&& st_r.i_sh[7:1] != `HUISP_DEVID_ADDR;
	assign room = st_r.b_cnt != 2'h2;
	assign pop = wr_valid && wr_ready;
	assign rd_val = (st_r.ra == `HUISP_BAUD_ADDR) ? st_r.baud : reg_rdata;
	assign slot = st_r.b_head ^ st_r.b_cnt[0];

	// ==========================================
	// Next state
	always_comb
	begin
		st_nxt = st_r;
		push_v = 1'b0;
		push_a = st_r.u_addr;
		push_d = st_r.u_hold_d;
		load = 1'b0;
		// Three-stage pin capture; a change counts once stages two and three agree
		st_nxt.s1 = {uart_read_trigger_pin, adr2, adr1, uart_rx, sda_in, scl_in, i2c_mode};
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.flt = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.flt);
		// Spike suppression on clock and data while I2C is selected
		for (int k = 0; k < 2; k++)
		begin
			st_nxt.ln_q[k] = st_r.ln_f[k];
			if (!mode || st_r.flt[k + 1] == st_r.ln_f[k])
			begin
				st_nxt.spk[k] = 3'h0;
				st_nxt.ln_f[k] = st_r.flt[k + 1];
			end
			else if (st_r.spk[k] == 3'(`HUISP_SPIKE_CYC - 1))
			begin
				st_nxt.spk[k] = 3'h0;
				st_nxt.ln_f[k] = st_r.flt[k + 1];
			end
			else
				st_nxt.spk[k] = st_r.spk[k] + 3'h1;
		end
		// Fractional reference tick generator
		st_nxt.acc = u_tick ? acc_sum - `HUISP_CLK_KHZ : acc_sum;

		// UART receiver, samples mid-bit, LSB first
		case (st_r.u_st)
			U_IDLE:
				if (!mode && !rx)
				begin
					st_nxt.u_st = U_START;
					st_nxt.u_cnt = nt >> 1;
				end
			U_START:
				if (u_tick && st_r.u_cnt == 13'h0)
				begin
					st_nxt.u_st = rx ? U_IDLE : U_DATA;
					st_nxt.u_cnt = nt - 13'h1;
					st_nxt.u_bit = 3'h0;
				end
				else if (u_tick)
					st_nxt.u_cnt = st_r.u_cnt - 13'h1;
			U_DATA:
				if (u_tick && st_r.u_cnt == 13'h0)
				begin
					st_nxt.u_sh = {rx, st_r.u_sh[7:1]};
					st_nxt.u_cnt = nt - 13'h1;
					st_nxt.u_bit = st_r.u_bit + 3'h1;
					if (st_r.u_bit == 3'h7)
						st_nxt.u_st = U_STOP;
				end
				else if (u_tick)
					st_nxt.u_cnt = st_r.u_cnt - 13'h1;
			U_STOP:
				if (u_tick && st_r.u_cnt == 13'h0)
					st_nxt.u_st = U_IDLE;
				else if (u_tick)
					st_nxt.u_cnt = st_r.u_cnt - 13'h1;
			default:
				st_nxt.u_st = U_IDLE;
		endcase

		// UART transmitter: start, eight data bits LSB first, stop
		// Runs before the request logic so a request in the same cycle is kept
		if (st_r.t_bit == 4'h0)
		begin
			if (st_r.t_pend)
			begin
				st_nxt.t_sh = {1'b1, st_r.t_byte, 1'b0};
				st_nxt.t_bit = 4'ha;
				st_nxt.t_cnt = nt - 13'h1;
				st_nxt.t_pend = 1'b0;
			end
		end
		else if (u_tick && st_r.t_cnt == 13'h0)
		begin
			st_nxt.t_sh = {1'b1, st_r.t_sh[9:1]};
			st_nxt.t_bit = st_r.t_bit - 4'h1;
			st_nxt.t_cnt = nt - 13'h1;
		end
		else if (u_tick)
			st_nxt.t_cnt = st_r.t_cnt - 13'h1;

		// Register read: waits for queued writes so it sees them
		st_nxt.re = 1'b0;
		if (st_r.re)
		begin
			st_nxt.rd_data = rd_val;
			if (st_r.rd_uart)
			begin
				st_nxt.t_pend = 1'b1;
				st_nxt.t_byte = rd_val;
			end
		end
		else if (st_r.rd_req && st_r.b_cnt == 2'h0)
		begin
			st_nxt.re = 1'b1;
			st_nxt.rd_req = 1'b0;
		end

		// UART byte protocol: address byte, then data for writes
		// Comes after the launch logic above so a new request wins over a clear
		if (st_r.u_hold && room)
		begin
			push_v = 1'b1;
			st_nxt.u_hold = 1'b0;
		end
		if (u_done && !st_r.u_have)
		begin
			if (st_r.u_sh[0])
			begin
				if (st_r.flt[6])
				begin
					st_nxt.rd_req = 1'b1;
					st_nxt.rd_uart = 1'b1;
					st_nxt.ra = st_r.u_sh[7:1];
				end
			end
			else
			begin
				st_nxt.u_have = 1'b1;
				st_nxt.u_addr = st_r.u_sh[7:1];
				st_nxt.t_pend = 1'b1;
				st_nxt.t_byte = st_r.u_sh;
			end
		end
		else if (u_done)
		begin
			st_nxt.u_have = 1'b0;
			st_nxt.u_hold = 1'b1;
			st_nxt.u_hold_d = st_r.u_sh;
		end

		// I2C slave; data line only ever changes on a clock fall
		if (!mode)
		begin
			st_nxt.i_st = I_IDLE;
			st_nxt.oe = 1'b0;
		end
		else if (i_start)
		begin
			st_nxt.i_st = I_ADDR;
			st_nxt.i_bit = 4'h0;
			st_nxt.oe = 1'b0;
		end
		else if (i_stop)
		begin
			st_nxt.i_st = I_IDLE;
			st_nxt.oe = 1'b0;
		end
		else
		begin
			case (st_r.i_st)
				I_ADDR, I_RX:
					if (i_rise && st_r.i_bit != 4'h8)
					begin
						st_nxt.i_sh = {st_r.i_sh[6:0], st_r.ln_f[1]};
						st_nxt.i_bit = st_r.i_bit + 4'h1;
					end
					else if (i_fall && st_r.i_bit == 4'h8 && st_r.i_st == I_ADDR)
					begin
						st_nxt.i_st = addr_match ? I_AACK : I_IDLE;
						st_nxt.oe = addr_match;
						st_nxt.i_rw = st_r.i_sh[0];
						st_nxt.i_first = 1'b1;
						if (addr_match && st_r.i_sh[0])
						begin
							st_nxt.rd_req = 1'b1;
							st_nxt.rd_uart = 1'b0;
							st_nxt.ra = st_r.i_ptr;
						end
					end
					else if (i_fall && st_r.i_bit == 4'h8)
					begin
						st_nxt.i_st = I_RACK;
						st_nxt.i_first = 1'b0;
						st_nxt.oe = 1'b1;
						if (st_r.i_first)
							st_nxt.i_ptr = st_r.i_sh[6:0];
						else if (room)
						begin
							push_v = 1'b1;
							push_a = st_r.i_ptr;
							push_d = st_r.i_sh;
							st_nxt.i_ptr = next_ptr(st_r.i_ptr);
						end
						else
							st_nxt.oe = 1'b0;
					end
				I_AACK:
					if (i_fall && st_r.i_rw)
						load = 1'b1;
					else if (i_fall)
					begin
						st_nxt.i_st = I_RX;
						st_nxt.i_bit = 4'h0;
						st_nxt.oe = 1'b0;
					end
				I_RACK:
					if (i_fall)
					begin
						st_nxt.i_st = I_RX;
						st_nxt.i_bit = 4'h0;
						st_nxt.oe = 1'b0;
					end
				I_TX:
					if (i_fall && st_r.i_bit == 4'h8)
					begin
						st_nxt.i_st = I_TACK;
						st_nxt.oe = 1'b0;
					end
					else if (i_fall)
					begin
						st_nxt.oe = !st_r.i_sh[7];
						st_nxt.i_sh = {st_r.i_sh[6:0], 1'b0};
						st_nxt.i_bit = st_r.i_bit + 4'h1;
					end
				I_TACK:
					if (i_rise)
					begin
						st_nxt.i_first = !st_r.ln_f[1];
						if (!st_r.ln_f[1])
						begin
							st_nxt.i_ptr = next_ptr(st_r.i_ptr);
							st_nxt.ra = next_ptr(st_r.i_ptr);
							st_nxt.rd_req = 1'b1;
							st_nxt.rd_uart = 1'b0;
						end
					end
					else if (i_fall && st_r.i_first)
						load = 1'b1;
					else if (i_fall)
						st_nxt.i_st = I_IDLE;
				default:
					st_nxt.i_st = I_IDLE;
			endcase
		end
		// Put the first bit of a fetched byte on the line
		if (load)
		begin
			st_nxt.i_st = I_TX;
			st_nxt.oe = !st_r.rd_data[7];
			st_nxt.i_sh = {st_r.rd_data[6:0], 1'b0};
			st_nxt.i_bit = 4'h1;
		end

		// Divider register is held here; other writes go to the buffer
		if (push_v && push_a == `HUISP_BAUD_ADDR)
			st_nxt.baud = push_d;
		else if (push_v)
		begin
			st_nxt.b_addr[slot] = push_a;
			st_nxt.b_data[slot] = push_d;
		end
		st_nxt.b_head = st_r.b_head ^ pop;
		st_nxt.b_cnt = st_r.b_cnt + {1'b0, push_v && push_a != `HUISP_BAUD_ADDR}
			- {1'b0, pop};
	end

	// ==========================================
	// State register
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	// ==========================================
	// Outputs
	assign uart_tx = st_r.t_sh[0];
	assign sda_out = 1'b0;
	assign sda_oe = st_r.oe;
	assign reg_re = st_r.re;
	assign reg_addr = st_r.ra;
	assign wr_valid = st_r.b_cnt != 2'h0;
	assign wr_addr = st_r.b_addr[st_r.b_head];
	assign wr_data = st_r.b_data[st_r.b_head];
	assign wr_room = room;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence s_tx_go;
		st_r.t_bit == 4'h0 && st_r.t_pend;
	endsequence
	sequence s_uart_wr_addr;
		u_done && !st_r.u_have && !st_r.u_sh[0];
	endsequence

	a_tx_start_bit: assert property (s_tx_go |=> !uart_tx && st_r.t_bit == 4'ha)
		else $error("start bit not sent");
	a_tx_lsb_first: assert property (s_tx_go |=> st_r.t_sh[8:1] == $past(st_r.t_byte))
		else $error("first data bit is not the lsb");
	a_tx_stop_high: assert property (st_r.t_bit == 4'h1 |-> uart_tx)
		else $error("stop bit not high");
	a_uart_echo: assert property (s_uart_wr_addr |=> st_r.t_pend && st_r.t_byte == $past(st_r.u_sh))
		else $error("write address not echoed");
	a_read_trigger: assert property (u_done && !st_r.u_have && st_r.u_sh[0] && !st_r.flt[6]
		&& !st_r.rd_req |=> !st_r.rd_req)
		else $error("read started without trigger");
	a_read_pulse: assert property (st_r.re |=> !st_r.re)
		else $error("read strobe longer than one cycle");
	a_addr_nomatch: assert property (i_fall && mode && !i_start && !i_stop && st_r.i_st == I_ADDR
		&& st_r.i_bit == 4'h8 && !addr_match |=> !sda_oe && st_r.i_st == I_IDLE)
		else $error("acknowledged a foreign address");
	a_oe_scl_low: assert property ($rose(sda_oe) |-> !st_r.ln_f[0])
		else $error("data line driven while clock high");
	a_start_addr: assert property (i_start && mode |=> st_r.i_st == I_ADDR && !sda_oe)
		else $error("start not handled");
	a_stop_idle: assert property (i_stop && mode |=> st_r.i_st == I_IDLE && !sda_oe)
		else $error("stop not handled");
	a_nack_release: assert property (st_r.i_st == I_TACK && i_fall && !st_r.i_first && mode
		&& !i_start && !i_stop |=> !sda_oe ##1 !sda_oe)
		else $error("line not released after nack");
	a_fifo_hold: assert property (push_v && mode && st_r.i_ptr == `HUISP_FIFO_ADDR
		|=> st_r.i_ptr == `HUISP_FIFO_ADDR)
		else $error("fifo pointer advanced");
	a_baud_update: assert property (push_v && push_a == `HUISP_BAUD_ADDR
		|=> st_r.baud == $past(push_d))
		else $error("divider not updated");
	a_buf_bound: assert property (st_r.b_cnt <= 2'h2)
		else $error("buffer overfilled");

endmodule
`default_nettype wire

// ==== shared/huisp_consts.svh ====
`ifndef HUISP_CONSTS_SVH
`define HUISP_CONSTS_SVH

// ==========================================
// Register map and fixed addresses
`define HUISP_BAUD_ADDR 7'h3b
`define HUISP_FIFO_ADDR 7'h05
`define HUISP_GCALL_ADDR 7'h00
`define HUISP_DEVID_ADDR 7'h7c
`define HUISP_BAUD_RST 8'h7a

// ==========================================
// Divider register fields
`define HUISP_BAUD_EXP 7:5
`define HUISP_BAUD_CNT 4:0
`define HUISP_DIV_ONE 13'h0001
`define HUISP_DIV_OFS 13'h0021

// ==========================================
// Reference clock emulation (27120 kHz out of 100000 kHz)
`define HUISP_REF_KHZ 17'h069f0
`define HUISP_CLK_KHZ 17'h186a0

// ==========================================
// Spike suppression and pin reset levels
`define HUISP_SPIKE_NS 50
`define HUISP_CLK_NS 10
`define HUISP_SPIKE_CYC ((`HUISP_SPIKE_NS + `HUISP_CLK_NS - 1) / `HUISP_CLK_NS)
`define HUISP_PIN_RST 7'h0e
`define HUISP_TX_IDLE 10'h3ff

`endif

// ==== shared/huisp_pkg.sv ====
`include "huisp_consts.svh"

package huisp_pkg;

	// ==========================================
	// State encodings
	typedef enum logic [1:0] {
		U_IDLE = 2'b00,
		U_START = 2'b01,
		U_DATA = 2'b10,
		U_STOP = 2'b11
	} huisp_urx_t;

	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_AACK = 3'b010,
		I_RX = 3'b011,
		I_RACK = 3'b100,
		I_TX = 3'b101,
		I_TACK = 3'b110
	} huisp_i2c_t;

	// ==========================================
	// Whole block state
	typedef struct packed {
		logic [6:0] s1;
		logic [6:0] s2;
		logic [6:0] s3;
		logic [6:0] flt;
		logic [1:0] ln_f;
		logic [1:0] ln_q;
		logic [1:0][2:0] spk;
		logic [16:0] acc;
		logic [7:0] baud;
		huisp_urx_t u_st;
		logic [12:0] u_cnt;
		logic [2:0] u_bit;
		logic [7:0] u_sh;
		logic u_have;
		logic [6:0] u_addr;
		logic u_hold;
		logic [7:0] u_hold_d;
		logic [12:0] t_cnt;
		logic [3:0] t_bit;
		logic [9:0] t_sh;
		logic t_pend;
		logic [7:0] t_byte;
		logic rd_req;
		logic rd_uart;
		logic re;
		logic [6:0] ra;
		logic [7:0] rd_data;
		logic [1:0][6:0] b_addr;
		logic [1:0][7:0] b_data;
		logic b_head;
		logic [1:0] b_cnt;
		huisp_i2c_t i_st;
		logic [3:0] i_bit;
		logic [7:0] i_sh;
		logic [6:0] i_ptr;
		logic i_first;
		logic i_rw;
		logic oe;
	} huisp_state_t;

	// Reset image: idle-high lines start high, divider at its default
	function automatic huisp_state_t huisp_rst_state();
		huisp_state_t s;
		s = '0;
		s.s1 = `HUISP_PIN_RST;
		s.s2 = `HUISP_PIN_RST;
		s.s3 = `HUISP_PIN_RST;
		s.flt = `HUISP_PIN_RST;
		s.ln_f = 2'h3;
		s.ln_q = 2'h3;
		s.baud = `HUISP_BAUD_RST;
		s.t_sh = `HUISP_TX_IDLE;
		return s;
	endfunction

endpackage

// ==== testbench/huisp_host.sv ====
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Host model: UART peer and I2C master
module huisp_host (
	// Clock
	input wire logic clk,
	// UART lines
	output logic rx,
	input wire logic tx,
	// I2C lines
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	int bt = 870;
	int q = 25;

	// Lines start idle high
	initial
	begin
		rx = 1'b1;
		scl = 1'b1;
		sda_m = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask

	// One 8N1 character, start low, LSB first, stop high
	task automatic u_send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rx = f[i];
			wt(bt);
		end
	endtask

	// Waits a bounded time for a start bit, samples mid-bit
	task automatic u_recv(output logic [7:0] d, output logic ok);
		logic [9:0] f;
		int n;
		n = 0;
		ok = 1'b0;
		d = 8'h00;
		while (tx !== 1'b0 && n < 40 * bt)
		begin
			wt(1);
			n++;
		end
		if (tx === 1'b0)
		begin
			wt(bt / 2);
			for (int i = 0; i < 10; i++)
			begin
				f[i] = tx;
				wt(bt);
			end
			d = f[8:1];
			ok = f[0] === 1'b0 && f[9] === 1'b1;
		end
	endtask

	// Data moves only while the clock is low
	task automatic i_bit(input logic b, output logic r);
		wt(q);
		sda_m = b;
		wt(q);
		scl = 1'b1;
		wt(q);
		r = sda;
		wt(q);
		scl = 1'b0;
	endtask

	// Start or repeated start
	task automatic i_start();
		wt(q);
		sda_m = 1'b1;
		wt(q);
		scl = 1'b1;
		wt(q);
		sda_m = 1'b0;
		wt(q);
		scl = 1'b0;
	endtask

	task automatic i_stop();
		wt(q);
		sda_m = 1'b0;
		wt(q);
		scl = 1'b1;
		wt(q);
		sda_m = 1'b1;
		wt(q);
	endtask

	// Byte out MSB first, then releases for the slave's acknowledge
	task automatic i_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			i_bit(b[i], r);
		i_bit(1'b1, r);
		ack = ~r;
	endtask

	// Byte in; a high acknowledge ends the read
	task automatic i_read(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++)
		begin
			i_bit(1'b1, r);
			d = {d[6:0], r};
		end
		i_bit(last, r);
	endtask
endmodule

`default_nettype wire

// ==== testbench/huisp_port_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "huisp_consts.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end

module huisp_port_tb_top;
	localparam logic [4:0] PFX = 5'h13; // Arbitrary value
	logic clk, nrst, i2c_mode, adr1, adr2, use_nv, trig, wr_ready;
	logic [1:0] nv_lo;
	logic [7:0] reg_rdata;
	logic [6:0] dev;
	logic [31:0] seed = 32'h000151df;
	logic [14:0] wq[$];
	logic [6:0] rq[$];
	int mismatches, n_tests;
	wire uart_rx, uart_tx, scl, sda_m, sda_out, sda_oe, reg_re, wr_valid, wr_room;
	wire [6:0] reg_addr, wr_addr;
	wire [7:0] wr_data;
	// Open-drain data line with pull-up
	wire sda_w = sda_m & (sda_oe ? sda_out : 1'b1);

	huisp_port #(.ADDR_PREFIX(PFX)) dut (
		.clk(clk), .nrst(nrst), .i2c_mode(i2c_mode), .adr1(adr1), .adr2(adr2),
		.use_nv_addr(use_nv), .nv_addr_lo(nv_lo), .uart_rx(uart_rx), .uart_tx(uart_tx),
		.uart_read_trigger_pin(trig), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .reg_re(reg_re), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_room(wr_room));

	huisp_host host (.clk(clk), .rx(uart_rx), .tx(uart_tx), .scl(scl), .sda_m(sda_m),
		.sda(sda_w));

	// ==========================================
	// Expectation helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Bit time in clock cycles for a divider setting
	function automatic int bcyc(input logic [7:0] d);
		int r;
		r = (d[7:5] == 3'h0) ? d[4:0] + 1 : (d[4:0] + 33) << (d[7:5] - 3'h1);
		return r * 10000 / 2712;
	endfunction

	function automatic logic [7:0] rdv(input logic [6:0] a);
		return {a, 1'b1} ^ 8'h3c;
	endfunction

	// ==========================================
	// Register file side and monitors
	always @(negedge clk)
		reg_rdata <= rdv(reg_addr);

	always @(posedge clk)
	begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1)
			wq.push_back({wr_addr, wr_data});
		if (reg_re === 1'b1)
			rq.push_back(reg_addr);
	end

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================
	// Tasks
	task automatic rst();
		nrst = 1'b0;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
	endtask

	task automatic chk_wr(input logic [6:0] a, input logic [7:0] d);
		logic [14:0] e;
		for (int i = 0; i < 400 && wq.size() == 0; i++)
			@(negedge clk);
		e = wq.size() ? wq.pop_front() : 'x;
		`CHK("write entry", {a, d}, e)
	endtask

	// UART write; data either overlaps the echo or follows it
	task automatic uwr(input logic [6:0] a, input logic [7:0] d, input logic par);
		logic [7:0] e;
		logic ok;
		fork
			begin
				host.u_send({a, 1'b0});
				if (par)
					host.u_send(d);
			end
			host.u_recv(e, ok);
		join
		if (!par)
			host.u_send(d);
		`CHK("echo", {a, 1'b0, 1'b1}, {e, ok})
	endtask

	task automatic urd(input logic [6:0] a, input logic t, input logic [7:0] x);
		logic [7:0] e;
		logic ok;
		trig = t;
		fork
			host.u_send({a, 1'b1});
			host.u_recv(e, ok);
		join
		`CHK("read reply", {t, x}, {ok, t ? e : x})
		`CHK("read addr", t ? {1'b1, a} : 8'h0, rq.size() ? {1'b1, rq[0]} : 8'h0)
		rq.delete();
		trig = 1'b1;
	endtask

	task automatic iwr(input logic [6:0] p, input int n, input logic [7:0] acks);
		logic a;
		logic [7:0] d[4];
		host.i_start();
		host.i_byte({dev, 1'b0}, a);
		`CHK("addr ack", 1'b1, a)
		host.i_byte({1'b0, p}, a);
		`CHK("ptr ack", 1'b1, a)
		for (int i = 0; i < n; i++)
		begin
			d[i] = 8'(xs());
			host.i_byte(d[i], a);
			`CHK("data ack", acks[i], a)
		end
		`CHK("room", acks[n - 1], wr_room)
		host.i_stop();
		wr_ready = 1'b1;
		for (int i = 0; i < n; i++)
			if (acks[i])
				chk_wr(p == `HUISP_FIFO_ADDR ? p : 7'(p + i), d[i]);
		`CHK("no extra entry", 0, wq.size())
	endtask

	task automatic ird(input logic [6:0] p);
		logic a;
		logic [7:0] d;
		host.i_start();
		host.i_byte({dev, 1'b0}, a);
		host.i_byte({1'b0, p}, a);
		host.i_start();
		host.i_byte({dev, 1'b1}, a);
		`CHK("read addr ack", 1'b1, a)
		for (int i = 0; i < 2; i++)
		begin
			host.i_read(i == 1, d);
			`CHK("read data", rdv(p == `HUISP_FIFO_ADDR ? p : 7'(p + i)), d)
		end
		host.i_stop();
		`CHK("released", 1'b0, sda_oe)
		rq.delete();
	endtask

	task automatic inak(input logic [7:0] b);
		logic a;
		host.i_start();
		host.i_byte(b, a);
		host.i_stop();
		`CHK("foreign ack", 1'b0, a)
	endtask

	task automatic conclude();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		repeat (95000) @(posedge clk);
		mismatches++;
		conclude();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		logic [31:0] r;
		logic [6:0] a;
		logic [7:0] d;
		mismatches = 0;
		n_tests = 0;
		{nrst, i2c_mode, adr1, adr2, use_nv, nv_lo} = 7'h08;
		{trig, wr_ready} = 2'h3;
		dev = {PFX, 2'b10};
		rst();
		`CHK("tx idle", 1'b1, uart_tx)
		`CHK("room", 1'b1, wr_room)
		`CHK("empty", 1'b0, wr_valid)
		// Default rate, then switch to setting 0x15
		host.bt = bcyc(`HUISP_BAUD_RST);
		uwr(`HUISP_BAUD_ADDR, 8'h15, 1'b0);
		host.bt = bcyc(8'h15);
		`CHK("divider kept local", 0, wq.size())
		urd(`HUISP_BAUD_ADDR, 1'b1, 8'h15);
		for (int k = 0; k < 4; k++)
		begin
			r = xs();
			a = r[6:0];
			d = r[15:8];
			if (a == `HUISP_BAUD_ADDR)
				a = 7'h3a;
			wr_ready = r[16];
			uwr(a, d, 1'b1);
			wr_ready = 1'b1;
			chk_wr(a, d);
			urd(a, 1'b1, rdv(a));
		end
		urd(7'h11, 1'b0, 8'h00);
		// I2C mode
		i2c_mode = 1'b1;
		rst();
		inak({dev ^ 7'h01, 1'b0});
		inak({`HUISP_GCALL_ADDR, 1'b0});
		inak({`HUISP_DEVID_ADDR, 1'b1});
		iwr(7'h20, 2, 8'h03);
		iwr(`HUISP_FIFO_ADDR, 2, 8'h03);
		wr_ready = 1'b0;
		iwr(7'h30, 3, 8'h03);
		ird(7'h20);
		{use_nv, nv_lo, adr2} = 4'b1010;
		dev = {PFX, 2'b01};
		repeat (8) @(negedge clk);
		ird(`HUISP_FIFO_ADDR);
		conclude();
	end
endmodule

`default_nettype wire
